// file: rtl/cam_pkg.sv
// shared constants and types for the core ALU datapath
// assumes a single core clock domain and an instruction decoder driving op requests
//
// Function
// - 16-bit datapath: add, sub, shift, logic
// - arithmetic treats values as two's complement
// - updates carry, zero, negative, overflow, half-carry
// - subtraction carry flags mean no borrow
// - size mode selects byte or word
// - operands/results from registers or memory
// - one shared 17x17 multiplier array
// - signed, unsigned, mixed, literal, 8x8 multiplies
// - signed/unsigned 32/16 and 16/16 divide
// - quotient to reg zero, remainder reg one
// - divisor any register; dividend aligned pair
// - one cycle per divisor bit, same length
// - barrel shift up to fifteen, one cycle
// - multi-bit shifts register direct only
// - arithmetic right, left, logical right shifts
// - control bit 3 shows priority above seven
// - top bit joins status bits 7:5
// - top bit resets zero, clear-only by write
// - bit 2 reads one, bits 15:4 and 1:0 zero
// - divide takes nineteen cycles
// - multiply completes in one cycle
// - iterative non-restoring divide, repeat-stepped
// - add/sub set overflow on signed wrap, else clear it; other ops keep it
package cam_pkg;
  localparam int DATA_W = 16;
  localparam int REG_AW = 4;
  localparam int DIV_CYCLES = 19;
  localparam int DIV_ITERS = 16;
  localparam int CCR_TOP_BIT = 3;
  localparam int CCR_ONE_BIT = 2;
  localparam logic [15:0] CCR_RESET = 16'h0004;
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_OV = 2;
  localparam int FLG_N = 3;
  localparam int FLG_DC = 4;
  localparam logic [REG_AW-1:0] QUOT_REG = 4'h0;
  localparam logic [REG_AW-1:0] REM_REG = 4'h1;

  typedef enum logic [3:0] {
    CAM_ADD = 4'h0, CAM_ADC = 4'h1, CAM_SUB = 4'h2, CAM_SBB = 4'h3,
    CAM_AND = 4'h4, CAM_OR  = 4'h5, CAM_XOR = 4'h6, CAM_ASR = 4'h7,
    CAM_SL  = 4'h8, CAM_LSR = 4'h9, CAM_MUL = 4'ha, CAM_DIV = 4'hb,
    CAM_MOV = 4'hc
  } cam_op_e;

  typedef enum logic [2:0] {
    MUL_SS = 3'h0, MUL_UU = 3'h1, MUL_US = 3'h2, MUL_SL5 = 3'h3,
    MUL_UL5 = 3'h4, MUL_U8 = 3'h5
  } cam_mul_e;

  typedef enum logic [1:0] {
    DIV_IDLE = 2'b00, DIV_RUN = 2'b01, DIV_FIX = 2'b11, DIV_DONE = 2'b10
  } cam_div_e;

  // C Z OV N DC
  typedef struct packed {
    logic dc;
    logic n;
    logic ov;
    logic z;
    logic c;
  } cam_flags_s;

  typedef struct packed {
    cam_op_e          op;
    logic             byteMode;
    logic             srcIsMem;
    logic             dstIsMem;
    cam_mul_e         mulMode;
    logic             divSigned;
    logic             divLong;
    logic [REG_AW-1:0] srcA;
    logic [REG_AW-1:0] srcB;
    logic [REG_AW-1:0] dst;
    logic [4:0]       shAmt;
  } cam_req_s;
endpackage

// file: rtl/cam_mul.sv
// 17x17 signed array; operands are sign or zero extended per mode
// assumes operands are stable during the cycle of the request
`timescale 1ns/1ps
`default_nettype none
module cam_mul
  import cam_pkg::*;
(
  input  wire logic [15:0] opA,
  input  wire logic [15:0] opB,
  input  wire logic [4:0]  lit,
  input  wire cam_mul_e    mode,
  output logic      [31:0] prod
);
  logic [16:0] extA;
  logic [16:0] extB;
  logic [33:0] full;

  always_comb begin
    extA = {1'b0, opA};
    extB = {1'b0, opB};
    case (mode)
      MUL_SS: begin
        extA = {opA[15], opA};
        extB = {opB[15], opB};
      end
      MUL_US: extB = {opB[15], opB};
      MUL_SL5: begin
        extA = {opA[15], opA};
        extB = {12'h000, lit};
      end
      MUL_UL5: extB = {12'h000, lit};
      MUL_U8: begin
        extA = {9'h000, opA[7:0]};
        extB = {9'h000, opB[7:0]};
      end
      default: ;
    endcase
  end

  // single shared array, one cycle
  assign full = 34'($signed(extA) * $signed(extB));
  assign prod = full[31:0];
endmodule
`default_nettype wire

// file: rtl/cam_div.sv
// iterative non-restoring divider, one quotient bit per step
// assumes start is a single-cycle pulse with operands valid alongside
`timescale 1ns/1ps
`default_nettype none
module cam_div
  import cam_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        clkEn,
  input  wire logic        start,
  input  wire logic        isSigned,
  input  wire logic [31:0] dividend,
  input  wire logic [15:0] divisor,
  output logic             busy,
  output logic             done,
  output logic [15:0]      quot,
  output logic [15:0]      rem,
  output logic [4:0]       stepCnt
);
  cam_div_e     state;
  logic [16:0]  part;
  logic [31:0]  dvd;
  logic [15:0]  dvs;
  logic         negQ;
  logic         negR;
  logic [4:0]   cnt;
  logic [16:0]  next_part;
  logic [15:0]  qFinal;
  logic [16:0]  rFix;
  logic [31:0]  dvdMag;

  assign busy = (state != DIV_IDLE);
  assign stepCnt = cnt;

  // non-restoring step: add or subtract by sign of partial remainder
  always_comb begin
    if (part[16]) begin
      next_part = {part[15:0], dvd[31]} + {1'b0, dvs};
    end else begin
      next_part = {part[15:0], dvd[31]} - {1'b0, dvs};
    end
    rFix = part[16] ? part + {1'b0, dvs} : part;
    qFinal = negQ ? 16'(-dvd[15:0]) : dvd[15:0];
    dvdMag = (isSigned && dividend[31]) ? -dividend : dividend;
  end

  // 1 load + 16 steps + fix + done = 19 cycles
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= DIV_IDLE;
      cnt <= 5'h00;
      part <= 17'h00000;
      dvd <= 32'h00000000;
      dvs <= 16'h0000;
      negQ <= 1'b0;
      negR <= 1'b0;
      done <= 1'b0;
      quot <= 16'h0000;
      rem <= 16'h0000;
    end else if (clkEn) begin
      done <= 1'b0;
      case (state)
        DIV_IDLE: begin
          if (start) begin
            // magnitudes first so the core loop is unsigned
            // high half seeds the remainder; quotient must fit in 16 bits
            dvd <= {dvdMag[15:0], 16'h0000};
            dvs <= (isSigned && divisor[15]) ? 16'(-divisor) : divisor;
            negQ <= isSigned && (dividend[31] ^ divisor[15]);
            negR <= isSigned && dividend[31];
            part <= {1'b0, dvdMag[31:16]};
            cnt <= 5'h00;
            state <= DIV_RUN;
          end
        end
        DIV_RUN: begin
          part <= next_part;
          dvd <= {dvd[30:0], ~next_part[16]};
          cnt <= cnt + 5'h01;
          if (cnt == 5'(DIV_ITERS - 1)) begin
            state <= DIV_FIX;
          end
        end
        DIV_FIX: begin
          quot <= qFinal;
          rem <= negR ? 16'(-rFix[15:0]) : rFix[15:0];
          state <= DIV_DONE;
        end
        DIV_DONE: begin
          done <= 1'b1;
          state <= DIV_IDLE;
        end
        default: state <= DIV_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: rtl/cam_alu.sv
// core ALU top: add/sub/logic, shifter, multiplier, divider, flags, control reg
// assumes the decoder holds a request for one cycle with reqValid and waits on busy
`timescale 1ns/1ps
`default_nettype none
module cam_alu
  import cam_pkg::*;
#(
  parameter int NREGS = 16
)(
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic         clkEn,
  input  wire logic         reqValid,
  input  wire cam_req_s     req,
  input  wire logic [15:0]  memRdata,
  input  wire logic         ccrWrEn,
  input  wire logic [15:0]  ccrWdata,
  input  wire logic         priorityRaise,
  input  wire logic [2:0]   priorityLowField,
  input  wire logic         regWrEn,
  input  wire logic [3:0]   regWrAddr,
  input  wire logic [15:0]  regWrData,
  output logic              busy,
  output logic              resValid,
  output logic [15:0]       result,
  output logic              memWrEn,
  output logic [15:0]       memWdata,
  output logic [15:0]       quotientWorkingReg,
  output logic [15:0]       remainderWorkingReg,
  output cam_flags_s        flags,
  output logic [15:0]       coreControlReg,
  output logic [3:0]        priorityLevel
);
  logic [15:0]  wreg [NREGS];
  logic [15:0]  opA;
  logic [15:0]  opB;
  logic [16:0]  sum;
  logic [4:0]   lowSum;
  logic [8:0]   byteSum;
  logic         carryIn;
  logic         isSub;
  logic [15:0]  bArg;
  logic [15:0]  aluRes;
  cam_flags_s   next_flags;
  logic [31:0]  prod;
  logic         divBusy;
  logic         divDone;
  logic [15:0]  divQ;
  logic [15:0]  divR;
  logic [31:0]  dividend;
  logic         priorityLevelTopBit;
  logic         writesReg;

  // register-direct operand source or data memory
  function automatic logic [15:0] pick(input logic fromMem, input logic [15:0] m,
                                       input logic [15:0] r);
    pick = fromMem ? m : r;
  endfunction

  // byte results keep only the low lane
  function automatic logic [15:0] lane(input logic bm, input logic [15:0] v);
    lane = bm ? {8'h00, v[7:0]} : v;
  endfunction

  // multi-bit shifts ignore the memory source
  assign opA = (req.op inside {CAM_ASR, CAM_SL, CAM_LSR}) ? wreg[req.srcA]
             : pick(req.srcIsMem, memRdata, wreg[req.srcA]);
  assign opB = wreg[req.srcB];

  // dividend from an aligned pair, high half odd register
  assign dividend = req.divLong
                  ? {wreg[{req.srcA[3:1], 1'b1}], wreg[{req.srcA[3:1], 1'b0}]}
                  : (req.divSigned ? {{16{opA[15]}}, opA} : {16'h0000, opA});

  // adder with inverted-borrow carry
  assign isSub = (req.op == CAM_SUB) || (req.op == CAM_SBB);
  assign bArg = isSub ? ~opB : opB;
  assign carryIn = (req.op == CAM_SUB) ? 1'b1
                 : ((req.op == CAM_ADC) || (req.op == CAM_SBB)) ? flags.c : 1'b0;
  assign sum = {1'b0, opA} + {1'b0, bArg} + {16'h0000, carryIn};
  assign byteSum = {1'b0, opA[7:0]} + {1'b0, bArg[7:0]} + {8'h00, carryIn};
  assign lowSum = {1'b0, opA[3:0]} + {1'b0, bArg[3:0]} + {4'h0, carryIn};

  cam_mul u_mul (
    .opA  (opA),
    .opB  (opB),
    .lit  (req.shAmt),
    .mode (req.mulMode),
    .prod (prod)
  );

  cam_div u_div (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clkEn    (clkEn),
    .start    (reqValid && !divBusy && req.op == CAM_DIV),
    .isSigned (req.divSigned),
    .dividend (dividend),
    .divisor  (opB),
    .busy     (divBusy),
    .done     (divDone),
    .quot     (divQ),
    .rem      (divR),
    .stepCnt  ()
  );

  always_comb begin
    aluRes = 16'h0000;
    next_flags = flags;
    case (req.op)
      CAM_ADD, CAM_ADC, CAM_SUB, CAM_SBB: begin
        aluRes = lane(req.byteMode, sum[15:0]);
        // carry and half carry from the width in use
        if (req.byteMode) begin
          next_flags.c = byteSum[8];
          next_flags.dc = lowSum[4];
          next_flags.ov = (opA[7] == bArg[7]) && (sum[7] != opA[7]);
        end else begin
          next_flags.c = sum[16];
          next_flags.dc = byteSum[8];
          next_flags.ov = (opA[15] == bArg[15]) && (sum[15] != opA[15]);
        end
      end
      CAM_AND: aluRes = lane(req.byteMode, opA & opB);
      CAM_OR:  aluRes = lane(req.byteMode, opA | opB);
      CAM_XOR: aluRes = lane(req.byteMode, opA ^ opB);
      // barrel shifts of 0..15 positions in one cycle
      CAM_ASR: begin
        aluRes = 16'($signed(opA) >>> req.shAmt[3:0]);
      end
      CAM_SL:  aluRes = opA << req.shAmt[3:0];
      CAM_LSR: aluRes = opA >> req.shAmt[3:0];
      CAM_MUL: aluRes = prod[15:0];
      CAM_MOV: aluRes = lane(req.byteMode, opA);
      default: aluRes = 16'h0000;
    endcase
    // z and n follow the result for data ops; mul and div leave flags alone
    if (!(req.op inside {CAM_MUL, CAM_DIV})) begin
      next_flags.z = req.byteMode ? (aluRes[7:0] == 8'h00) : (aluRes == 16'h0000);
      next_flags.n = req.byteMode ? aluRes[7] : aluRes[15];
    end
  end

  assign writesReg = reqValid && !divBusy && req.op != CAM_DIV
                   && !(req.dstIsMem && !(req.op inside {CAM_ASR, CAM_SL, CAM_LSR}));

  // working register array; divide results land in fixed slots
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NREGS; i++) begin
        wreg[i] <= 16'h0000;
      end
    end else if (clkEn) begin
      if (divDone) begin
        wreg[QUOT_REG] <= divQ;
        wreg[REM_REG] <= divR;
      end else if (writesReg) begin
        if (req.op == CAM_MUL && req.mulMode != MUL_U8) begin
          wreg[req.dst] <= prod[15:0];
          wreg[{req.dst[3:1], 1'b1}] <= prod[31:16];
        end else begin
          wreg[req.dst] <= req.byteMode ? {wreg[req.dst][15:8], aluRes[7:0]} : aluRes;
        end
      end else if (regWrEn) begin
        wreg[regWrAddr] <= regWrData;
      end
    end
  end

  // result port and memory write path
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      resValid <= 1'b0;
      result <= 16'h0000;
      memWrEn <= 1'b0;
      memWdata <= 16'h0000;
      busy <= 1'b0;
      quotientWorkingReg <= 16'h0000;
      remainderWorkingReg <= 16'h0000;
    end else if (clkEn) begin
      resValid <= (reqValid && !divBusy && req.op != CAM_DIV) || divDone;
      result <= divDone ? divQ : aluRes;
      memWrEn <= reqValid && !divBusy && req.dstIsMem
               && !(req.op inside {CAM_ASR, CAM_SL, CAM_LSR, CAM_DIV});
      memWdata <= aluRes;
      busy <= divBusy || (reqValid && req.op == CAM_DIV);
      quotientWorkingReg <= divDone ? divQ : wreg[QUOT_REG];
      remainderWorkingReg <= divDone ? divR : wreg[REM_REG];
    end
  end

  // status flags update only on a taken data op
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flags <= '0;
    end else if (clkEn && reqValid && !divBusy) begin
      flags <= next_flags;
    end
  end

  // top priority bit: hardware set wins over a software clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      priorityLevelTopBit <= 1'b0;
    end else if (clkEn) begin
      if (priorityRaise) begin
        priorityLevelTopBit <= 1'b1;
      end else if (ccrWrEn && !ccrWdata[CCR_TOP_BIT]) begin
        priorityLevelTopBit <= 1'b0;
      end
    end
  end

  // read view: bit 2 reads one, unimplemented bits zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      coreControlReg <= CCR_RESET;
      priorityLevel <= 4'h0;
    end else if (clkEn) begin
      coreControlReg <= CCR_RESET | (16'(priorityLevelTopBit) << CCR_TOP_BIT);
      priorityLevel <= {priorityLevelTopBit, priorityLowField};
    end
  end
endmodule
`default_nettype wire

// file: sim/cam_alu_asserts.sv
// checker for the ALU top: op latency, control register and flag relations
// assumes clkEn is high whenever a request is taken
`timescale 1ns/1ps
`default_nettype none
module cam_alu_asserts
  import cam_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        clkEn,
  input wire logic        reqValid,
  input wire cam_req_s    req,
  input wire logic        ccrWrEn,
  input wire logic [15:0] ccrWdata,
  input wire logic        priorityRaise,
  input wire logic [2:0]  priorityLowField,
  input wire logic        busy,
  input wire logic        resValid,
  input wire logic [15:0] result,
  input wire logic        memWrEn,
  input wire cam_flags_s  flags,
  input wire logic [15:0] coreControlReg,
  input wire logic [3:0]  priorityLevel
);
  logic take;
  logic prevLogic;
  logic prevByte;
  assign take = reqValid && clkEn && !busy;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prevLogic <= 1'b0;
      prevByte  <= 1'b0;
    end else begin
      prevLogic <= take && req.op inside {CAM_AND, CAM_OR, CAM_XOR};
      prevByte  <= req.byteMode;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_ccr_fixed;
    coreControlReg[15:4] == 12'h000 && coreControlReg[2] && coreControlReg[1:0] == 2'h0;
  endproperty
  property p_ccr_noset;
    ccrWrEn && clkEn && !priorityRaise && !$past(priorityRaise) && !coreControlReg[3]
      |-> ##2 !coreControlReg[3];
  endproperty
  property p_ccr_clr;
    ccrWrEn && clkEn && !ccrWdata[3] && !priorityRaise |-> ##2 !coreControlReg[3];
  endproperty
  property p_raise;
    priorityRaise && clkEn |-> ##2 coreControlReg[3];
  endproperty
  property p_prio;
    clkEn && $past(clkEn) && $stable(priorityLowField) && $stable(coreControlReg[3])
      |-> priorityLevel == {coreControlReg[3], priorityLowField};
  endproperty
  property p_single;
    take && req.op != CAM_DIV |=> resValid;
  endproperty
  property p_div_quiet;
    take && req.op == CAM_DIV |=> (busy && !resValid) [*8];
  endproperty
  property p_div_len;
    take && req.op == CAM_DIV |-> ##[18:20] resValid;
  endproperty
  property p_mul_flags;
    take && req.op == CAM_MUL |=> $stable(flags);
  endproperty
  property p_logic_flags;
    prevLogic && resValid
      |-> flags.z == (result == 16'h0000) && flags.n == (prevByte ? result[7] : result[15]);
  endproperty
  property p_shift_reg;
    take && req.op inside {CAM_ASR, CAM_SL, CAM_LSR} |=> !memWrEn;
  endproperty
  a_ccr_fixed:
    assert property (p_ccr_fixed) else $error("control reg fixed bits wrong");
  a_ccr_noset:
    assert property (p_ccr_noset) else $error("write set the top bit");
  a_ccr_clr:
    assert property (p_ccr_clr) else $error("write did not clear the top bit");
  a_raise:
    assert property (p_raise) else $error("raise did not set the top bit");
  a_prio:
    assert property (p_prio) else $error("priority level not joined");
  a_single:
    assert property (p_single) else $error("single cycle op late");
  a_div_quiet:
    assert property (p_div_quiet) else $error("divide ended early");
  a_div_len:
    assert property (p_div_len) else $error("divide length wrong");
  a_mul_flags:
    assert property (p_mul_flags) else $error("multiply changed flags");
  a_logic_flags:
    assert property (p_logic_flags) else $error("logic zero or negative flag wrong");
  a_shift_reg:
    assert property (p_shift_reg) else $error("shift wrote memory");
  c_div: cover property (take && req.op == CAM_DIV);
  c_mul: cover property (take && req.op == CAM_MUL);
  c_clr: cover property (ccrWrEn && coreControlReg[3]);
endmodule
bind cam_alu cam_alu_asserts cam_alu_asserts_i (
  .core_clk(core_clk), .rstn(rstn), .clkEn(clkEn), .reqValid(reqValid), .req(req),
  .ccrWrEn(ccrWrEn), .ccrWdata(ccrWdata), .priorityRaise(priorityRaise),
  .priorityLowField(priorityLowField), .busy(busy), .resValid(resValid),
  .result(result), .memWrEn(memWrEn), .flags(flags), .coreControlReg(coreControlReg),
  .priorityLevel(priorityLevel)
);
`default_nettype wire

// file: sim/cam_dec_model.sv
// decoder model: issues one request per go pulse and supplies the memory operand
// assumes go is a one-cycle pulse driven just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module cam_dec_model
  import cam_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        busy,
  input  wire logic        go,
  input  wire cam_req_s    reqIn,
  input  wire logic [15:0] memIn,
  output logic             reqValid,
  output cam_req_s         req,
  output logic [15:0]      memRdata
);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reqValid <= 1'b0;
      req      <= '0;
      memRdata <= 16'h0000;
    end else if (go && !busy) begin
      reqValid <= 1'b1;
      req      <= reqIn;
      memRdata <= memIn;
    end else begin
      reqValid <= 1'b0;
      // a stale operand must never look like a valid one
      memRdata <= ~memRdata;
    end
  end
endmodule
`default_nettype wire

// file: sim/test_cpu_alu_mul_div_shift.sv
// self-checking bench for the ALU top with a decoder model in front
// assumes one 100 MHz clock; inputs move 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module test_cpu_alu_mul_div_shift;
  import cam_pkg::*;
  logic       core_clk, rstn, clkEn, go, ccrWrEn, priorityRaise, regWrEn;
  logic       reqValid, busy, resValid, memWrEn;
  logic [15:0] ccrWdata, regWrData, memIn, memRdata, result, memWdata, q, r, ccr;
  logic [2:0]  priorityLowField;
  logic [3:0]  regWrAddr, priorityLevel;
  cam_req_s    reqIn, req;
  cam_flags_s  flags, saved;
  int          n_fail, check_count, cycles, n0, n;
  cam_alu cam_alu_i (.core_clk(core_clk), .rstn(rstn), .clkEn(clkEn),
    .reqValid(reqValid), .req(req), .memRdata(memRdata), .ccrWrEn(ccrWrEn),
    .ccrWdata(ccrWdata), .priorityRaise(priorityRaise), .priorityLowField(priorityLowField),
    .regWrEn(regWrEn), .regWrAddr(regWrAddr), .regWrData(regWrData), .busy(busy),
    .resValid(resValid), .result(result), .memWrEn(memWrEn), .memWdata(memWdata),
    .quotientWorkingReg(q), .remainderWorkingReg(r), .flags(flags),
    .coreControlReg(ccr), .priorityLevel(priorityLevel));
  cam_dec_model cam_dec_model_i (.core_clk(core_clk), .rstn(rstn), .busy(busy), .go(go),
    .reqIn(reqIn), .memIn(memIn), .reqValid(reqValid), .req(req), .memRdata(memRdata));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkf(input cam_flags_s got, input cam_flags_s exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t flags %b expected %b", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regWrEn = 1'b1;
    regWrAddr = a;
    regWrData = d;
    tick();
    regWrEn = 1'b0;
  endtask
  function automatic cam_req_s mk(cam_op_e op, logic [3:0] a, logic [3:0] b, logic [3:0] s);
    cam_req_s x;
    x = '0;
    x.op = op;
    x.srcA = a;
    x.srcB = b;
    x.shAmt = {1'b0, s};
    return x;
  endfunction
  // waits for the answer; n returns the cycles it took
  task automatic run(input cam_req_s x, input logic [15:0] m);
    reqIn = x;
    memIn = m;
    go = 1'b1;
    tick();
    go = 1'b0;
    for (n = 0; n < 40 && resValid !== 1'b1; n++) tick();
    chk({31'h0, resValid}, 32'h1);
  endtask
  task automatic t_arith;
    cam_req_s x;
    wr(4'h2, 16'h7fff);
    wr(4'h3, 16'h0001);
    run(mk(CAM_ADD, 4'h2, 4'h3, 4'h0), 16'h0);
    chk(result, 16'h8000);
    chkf(flags, 5'b11100);
    run(mk(CAM_ADD, 4'h3, 4'h3, 4'h0), 16'h0);
    chkf(flags, 5'b00000);
    wr(4'h2, 16'h0005);
    run(mk(CAM_SUB, 4'h2, 4'h3, 4'h0), 16'h0);
    chk(result, 16'h0004);
    chkf(flags, 5'b10001);
    run(mk(CAM_SUB, 4'h3, 4'h2, 4'h0), 16'h0);
    chk(result, 16'hfffc);
    chkf(flags, 5'b01000);
    wr(4'h2, 16'h12ff);
    x = mk(CAM_ADD, 4'h2, 4'h3, 4'h0);
    x.byteMode = 1'b1;
    run(x, 16'h0);
    chk(result[7:0], 8'h00);
    chkf(flags, 5'b10011);
    run(mk(CAM_ADC, 4'h3, 4'h3, 4'h0), 16'h0);
    chk(result, 16'h0003);
    chkf(flags, 5'b00000);
    run(mk(CAM_SBB, 4'h3, 4'h3, 4'h0), 16'h0);
    chk(result, 16'hffff);
    chkf(flags, 5'b01000);
  endtask
  task automatic t_logic_shift;
    cam_op_e ops[6] = '{CAM_AND, CAM_OR, CAM_XOR, CAM_ASR, CAM_SL, CAM_LSR};
    logic [15:0] src[6] = '{16'hf0f0, 16'hf0f0, 16'hf0f0, 16'h8000, 16'h0001, 16'h8000};
    logic [15:0] exp[6] = '{16'hf0f0, 16'hfff0, 16'h0f00, 16'hffff, 16'h8000, 16'h0001};
    wr(4'h3, 16'hfff0);
    for (int i = 0; i < 6; i++) begin
      wr(4'h2, src[i]);
      run(mk(ops[i], 4'h2, 4'h3, 4'hf), 16'h0);
      chk(result, exp[i]);
    end
  endtask
  task automatic t_mem;
    cam_req_s x;
    x = mk(CAM_MOV, 4'h2, 4'h3, 4'h0);
    x.srcIsMem = 1'b1;
    x.dstIsMem = 1'b1;
    run(x, 16'ha5c3);
    chk({31'h0, memWrEn}, 32'h1);
    chk(memWdata, 16'ha5c3);
  endtask
  task automatic t_mul;
    cam_mul_e md[6] = '{MUL_SS, MUL_UU, MUL_US, MUL_SL5, MUL_UL5, MUL_U8};
    logic [15:0] a[6] = '{16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h33ff};
    logic [15:0] b[6] = '{16'h0002, 16'h0002, 16'hffff, 16'h0000, 16'h0000, 16'h7710};
    logic [31:0] e[6] = '{32'hfffffffe, 32'h0001fffe, 32'hffff0001, 32'hfffffffd,
                          32'h0002fffd, 32'h5a5a0ff0};
    cam_req_s x;
    saved = flags;
    for (int i = 0; i < 6; i++) begin
      wr(4'h2, a[i]);
      wr(4'h3, b[i]);
      wr(4'h1, 16'h5a5a);
      x = mk(CAM_MUL, 4'h2, 4'h3, 4'h3);
      x.mulMode = md[i];
      run(x, 16'h0);
      // the reg0/reg1 view trails the register write by one cycle
      tick();
      chk({r, q}, e[i]);
      chkf(flags, saved);
    end
  endtask
  task automatic t_div;
    logic [15:0] lo[4] = '{16'h0000, 16'hfff9, 16'hfff9, 16'hfff9};
    logic [15:0] hi[4] = '{16'h0001, 16'hffff, 16'h0000, 16'h0000};
    logic [31:0] e[4] = '{32'h00015555, 32'hfffffffd, 32'h00017ffc, 32'hfffffffd};
    cam_req_s x;
    for (int i = 0; i < 4; i++) begin
      wr(4'h2, lo[i]);
      wr(4'h3, hi[i]);
      wr(4'h4, 16'h0002 + {15'h0, i == 0});
      // odd base register still selects the aligned pair
      x = mk(CAM_DIV, (i < 2) ? 4'h3 : 4'h2, 4'h4, 4'h0);
      x.divLong = (i < 2);
      x.divSigned = i[0];
      run(x, 16'h0);
      chk({r, q}, e[i]);
      if (i == 0) n0 = n;
      chk(n, n0);
      chk(n, DIV_CYCLES + 1);
    end
  endtask
  task automatic t_ccr;
    chk(ccr, 16'h0004);
    ccrWrEn = 1'b1;
    ccrWdata = 16'hffff;
    tick();
    ccrWrEn = 1'b0;
    tick();
    chk(ccr, 16'h0004);
    priorityLowField = 3'h5;
    priorityRaise = 1'b1;
    tick();
    priorityRaise = 1'b0;
    tick();
    tick();
    chk(ccr, 16'h000c);
    chk(priorityLevel, 4'hd);
    ccrWrEn = 1'b1;
    ccrWdata = 16'h0000;
    tick();
    ccrWrEn = 1'b0;
    tick();
    tick();
    chk(ccr, 16'h0004);
    chk(priorityLevel, 4'h5);
  endtask
  initial begin
    {rstn, go, ccrWrEn, priorityRaise, regWrEn, ccrWdata, regWrData, memIn} = '0;
    {priorityLowField, regWrAddr, reqIn} = '0;
    clkEn = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 rstn = 1'b1;
    t_ccr();
    t_arith();
    t_logic_shift();
    t_mem();
    t_mul();
    t_div();
    print_verdict();
  end
endmodule
`default_nettype wire
